// file: logic/hdg_defs.svh
// Constants for the host/device DMA, interrupt and select glue.
// Assumes one 10 MHz clock shared by both ends of the link.
// What this block does
// - Device drops download request two clocks early.
// - Servicing strobe drops data and instruction request.
// - Host downloads with destination-synchronized writes.
// - Host uploads with source-synchronized reads.
// - Upload request gone before deposit first state.
// - Device accesses get one internal wait state.
// - Open-drain requests pulled high when released.
// - Acknowledge input held inactive high permanently.
// - I/O pointers keep top four bits zero.
// - Acknowledge write clears ones, keeps zeros.
// - Interrupt stays until enabled requests cleared.
// - Service routine writes the acknowledge register.
// - Latched address bits one, two select registers.
// - Seven 128-byte select regions above base.
// - Peripheral selects idle until both configs accessed.
// - Zero to three waits, external ready optional.
// - Range config bit 7 picks memory space.
// - Reset: upper select, top 1K, 3 waits.
// - Only lower 16 address bits latched.
`ifndef HDG_DEFS_SVH
`define HDG_DEFS_SVH
// ----------------------------------------------------------------
// Host software registers (word index).
// ----------------------------------------------------------------
`define HDG_R_CTRL   4'h0
`define HDG_R_COUNT  4'h1
`define HDG_R_PTR    4'h2
`define HDG_R_BASE   4'h3
`define HDG_R_RANGE  4'h4
`define HDG_R_STAT   4'h5
`define HDG_R_MASK   4'h6
`define HDG_R_ACCESS 4'h7
`define HDG_R_DATA   4'h8
// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define HDG_CTRL_GO    0
`define HDG_CTRL_DIR   1
`define HDG_CTRL_CHAN  2
`define HDG_CTRL_IO    3
`define HDG_CTRL_UEXT  4
`define HDG_CTRL_BUSY  7
`define HDG_ACC_IO     20
`define HDG_ACC_RD     21
`define HDG_MEM_BIT    7
`define HDG_RDY_IGN    2
`define HDG_UCS_WAITS  2'h3
`define HDG_UCS_EXT    1'b1
`define HDG_WIN_LSB    10
`define HDG_IO_TOP     4'h0
`define HDG_NSEL       7
// ----------------------------------------------------------------
// Device registers, selected by the two register-select inputs.
// ----------------------------------------------------------------
`define HDG_D_DATA     2'h0
`define HDG_D_INSTR    2'h1
`define HDG_D_ENABLE   2'h2
`define HDG_D_ACK      2'h3
`endif

// file: logic/hdg_pkg.sv
// Types shared by both ends of the glue.
// Assumes hdg_defs.svh supplies the numeric constants.
package hdg_pkg;
   typedef logic [15:0] hdg_word_t;
   typedef logic [3:0]  hdg_irq_t;
   typedef enum logic [2:0] {HDG_IDLE, HDG_T1, HDG_T2, HDG_T3, HDG_TW, HDG_T4} hdg_bus_t;
   typedef struct packed {
      logic      rd_prev;
      logic      wr_prev;
      logic      darm;
      logic      iarm;
      hdg_word_t rdata;
      hdg_word_t wdata;
      hdg_irq_t  pend;
      hdg_irq_t  ena;
      logic      irq;
      logic      dl_pls;
      logic      in_pls;
      logic      ul_pls;
   } hdg_dev_st_t;
   typedef struct packed {
      hdg_bus_t    bus;
      logic [1:0]  waits;
      logic [15:0] lat_addr;
      logic [19:0] cur_addr;
      logic        cur_io;
      logic        cur_rd;
      logic        cur_dma;
      hdg_word_t   wdata;
      hdg_word_t   rdata;
      logic        busy;
      logic        dir;
      logic        chan;
      logic        ptr_io;
      logic        ucs_ext;
      logic [1:0]  ucs_w;
      logic [15:0] count;
      logic [19:0] ptr;
      logic [15:0] base;
      logic [15:0] rng;
      logic [1:0]  touched;
      logic [1:0]  stat;
      logic [1:0]  mask;
      logic        man;
      logic [21:0] man_acc;
      hdg_word_t   man_data;
      logic [31:0] sw_rdata;
      hdg_word_t   ul_data;
      logic        ul_pls;
      logic        xr1;
      logic        xr2;
   } hdg_host_st_t;
endpackage : hdg_pkg

// file: logic/hdg_link_if.sv
// Pins between the host and the device, with wire resolution.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface hdg_link_if;
   logic        sel_n;
   logic [1:0]  reg_sel;
   logic        rd_n;
   logic        wr_n;
   logic [15:0] hd_out;
   logic        hd_oe;
   logic [15:0] dd_out;
   logic        dd_oe;
   logic [15:0] data;
   logic        data_queue_request_o;
   logic        data_queue_request_oe;
   logic        ireq_o;
   logic        ireq_oe;
   logic        data_queue_request;
   logic        ireq;
   logic        dev_int;
   logic        ack_n;
   // pull-up model
   // A released request line floats high through the resistor.
   assign data_queue_request = data_queue_request_oe ? data_queue_request_o : 1'b1;
   assign ireq = ireq_oe ? ireq_o : 1'b1;
   assign data = dd_oe ? dd_out : (hd_oe ? hd_out : 16'hFFFF);
   modport dev_mp  (input sel_n, reg_sel, rd_n, wr_n, data, ack_n,
                    output dd_out, dd_oe, data_queue_request_o, data_queue_request_oe, ireq_o, ireq_oe, dev_int);
   modport host_mp (input data, data_queue_request, ireq, dev_int,
                    output sel_n, reg_sel, rd_n, wr_n, hd_out, hd_oe, ack_n);
endinterface : hdg_link_if

// file: logic/hdg_dev_end.sv
// Device end: data and instruction ports, request lines, interrupts.
// Assumes the host strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "hdg_defs.svh"
module hdg_dev_end (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Link to host
   hdg_link_if.dev_mp      lk,
   // Download side
   input  wire logic       dl_space,
   output hdg_pkg::hdg_word_t dl_data,
   output logic            dl_wr,
   output logic            in_wr,
   input  wire logic       in_space,
   // Upload side
   input  wire logic       ul_avail,
   input  wire hdg_pkg::hdg_word_t ul_data,
   output logic            ul_taken,
   // Interrupt events
   input  wire hdg_pkg::hdg_irq_t irq_event
);
   import hdg_pkg::*;
   hdg_dev_st_t q;
   hdg_dev_st_t d;
   logic        rd_act;
   logic        wr_act;
   logic        rd_start;
   logic        wr_start;
   hdg_irq_t    clr;

   always_comb
   begin
      d        = q;
      d.dl_pls = 1'b0;
      d.in_pls = 1'b0;
      d.ul_pls = 1'b0;
      clr      = '0;
      rd_act   = ~lk.sel_n & ~lk.rd_n;
      wr_act   = ~lk.sel_n & ~lk.wr_n;
      rd_start = rd_act & ~q.rd_prev;
      wr_start = wr_act & ~q.wr_prev;
      d.rd_prev = rd_act;
      d.wr_prev = wr_act;
      // Requests rearm only once the strobe is released, so one
      // access never produces a second transfer.
      if (!rd_act && !wr_act)
      begin
         d.darm = 1'b1;
         d.iarm = 1'b1;
      end
      if (wr_start)
      begin
         case (lk.reg_sel)
            `HDG_D_DATA:
            begin
               d.wdata  = lk.data;
               d.dl_pls = 1'b1;
               d.darm   = 1'b0;
            end
            `HDG_D_INSTR:
            begin
               d.wdata  = lk.data;
               d.in_pls = 1'b1;
               d.iarm   = 1'b0;
            end
            `HDG_D_ENABLE: d.ena = lk.data[3:0];
            `HDG_D_ACK:    clr = lk.data[3:0];
            default:       d.ena = q.ena;
         endcase
      end
      if (rd_start)
      begin
         case (lk.reg_sel)
            `HDG_D_DATA:
            begin
               d.rdata  = ul_data;
               d.ul_pls = 1'b1;
               d.darm   = 1'b0;
            end
            `HDG_D_ENABLE: d.rdata = {12'h000, q.ena};
            `HDG_D_ACK:    d.rdata = {12'h000, q.pend};
            default:       d.rdata = 16'h0000;
         endcase
      end
      // A new event in the acknowledge cycle survives the clear.
      d.pend = (q.pend & ~clr) | irq_event;
      d.irq  = |(d.pend & d.ena);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign lk.data_queue_request_o  = 1'b0;
   assign lk.data_queue_request_oe = ~(q.darm & (dl_space | ul_avail));
   assign lk.ireq_o  = 1'b0;
   assign lk.ireq_oe = ~(q.iarm & in_space);
   assign lk.dd_out  = q.rdata;
   assign lk.dd_oe   = ~lk.sel_n & ~lk.rd_n & q.rd_prev;
   assign lk.dev_int = q.irq;
   assign dl_data    = q.wdata;
   assign dl_wr      = q.dl_pls;
   assign in_wr      = q.in_pls;
   assign ul_taken   = q.ul_pls;
endmodule : hdg_dev_end

// file: logic/hdg_host_end.sv
// Host end: bus cycle sequencer, DMA channel, selects, ready unit.
// Assumes software on a plain port and the device on the link.
`timescale 1ns/1ps
`include "hdg_defs.svh"
module hdg_host_end (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Software port
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [31:0]      sw_rdata,
   output logic             irq,
   // Download source
   input  wire logic        dl_valid,
   input  wire hdg_pkg::hdg_word_t dl_data,
   output logic             dl_ready,
   // Upload sink
   output logic             ul_valid,
   output hdg_pkg::hdg_word_t ul_data,
   // Board pins
   input  wire logic        ext_ready,
   output logic [6:0]       peripheral_select_line_n,
   output logic             upper_memory_select_n,
   // Link to device
   hdg_link_if.host_mp      lk
);
   import hdg_pkg::*;
   hdg_host_st_t q;
   hdg_host_st_t d;
   logic [7:0]   sel;
   logic [2:0]   rmode;
   logic         bus_on;
   logic         stb;
   logic         req;
   logic         rdy_ok;
   logic [1:0]   sclr;

   // ----------------------------------------------------------------
   // Select decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] sel_decode(input logic [19:0] a, input logic io,
                                             input logic [15:0] base,
                                             input logic [15:0] rng,
                                             input logic [1:0] tch);
      logic [19:0] off;
      logic [7:0]  r;
      off = a - {base[15:6], 10'h000};
      r   = '0;
      r[7] = ~io & (&a[19:`HDG_WIN_LSB]);
      for (int i = 0; i < `HDG_NSEL; i++)
      begin
         r[i] = (&tch) & (io != rng[`HDG_MEM_BIT]) & (off[19:10] == 10'h000)
                & (off[9:7] == 3'(i));
      end
      return r;
   endfunction : sel_decode

   function automatic logic [2:0] sel_ready(input logic [7:0] s, input logic [15:0] base,
                                            input logic [15:0] rng, input logic uext,
                                            input logic [1:0] uw);
      logic [2:0] m;
      m = 3'h0;
      if (|s[3:0])
         m = base[2:0];
      else if (|s[6:4])
         m = rng[2:0];
      else if (s[7])
         m = {~uext, uw};
      return m;
   endfunction : sel_ready

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      d        = q;
      d.ul_pls = 1'b0;
      d.sw_rdata = 32'h0000_0000;
      d.xr1    = ext_ready;
      d.xr2    = q.xr1;
      sclr     = 2'h0;
      sel      = sel_decode(q.cur_addr, q.cur_io, q.base, q.rng, q.touched);
      rmode    = sel_ready(sel, q.base, q.rng, q.ucs_ext, q.ucs_w);
      bus_on   = (q.bus == HDG_T2) || (q.bus == HDG_T3) || (q.bus == HDG_TW)
                 || (q.bus == HDG_T4);
      stb      = bus_on && (q.bus != HDG_T4);
      // An unselected address has no internal ready at all.
      rdy_ok   = rmode[`HDG_RDY_IGN] | q.xr2;
      req      = q.chan ? lk.ireq : lk.data_queue_request;
      dl_ready = (q.bus == HDG_IDLE) && !q.man && q.busy && (q.count != 16'h0000)
                 && !q.dir && req && dl_valid;
      if (sw_wr)
      begin
         case (sw_addr)
            `HDG_R_CTRL:
            begin
               if (sw_wdata[`HDG_CTRL_GO])
                  d.busy = 1'b1;
               d.dir     = sw_wdata[`HDG_CTRL_DIR];
               d.chan    = sw_wdata[`HDG_CTRL_CHAN];
               d.ptr_io  = sw_wdata[`HDG_CTRL_IO];
               d.ucs_ext = sw_wdata[`HDG_CTRL_UEXT];
               d.ucs_w   = sw_wdata[6:5];
            end
            `HDG_R_COUNT:  d.count = sw_wdata[15:0];
            `HDG_R_PTR:    d.ptr = sw_wdata[19:0];
            `HDG_R_BASE:
            begin
               d.base       = sw_wdata[15:0];
               d.touched[0] = 1'b1;
            end
            `HDG_R_RANGE:
            begin
               d.rng        = sw_wdata[15:0];
               d.touched[1] = 1'b1;
            end
            `HDG_R_STAT:   sclr = sw_wdata[1:0];
            `HDG_R_MASK:   d.mask = sw_wdata[1:0];
            `HDG_R_ACCESS:
            begin
               d.man     = 1'b1;
               d.man_acc = sw_wdata[21:0];
            end
            `HDG_R_DATA:   d.man_data = sw_wdata[15:0];
            default:       d.mask = q.mask;
         endcase
      end
      if (sw_rd)
      begin
         case (sw_addr)
            `HDG_R_CTRL:   d.sw_rdata = {24'h0, q.busy, q.ucs_w, q.ucs_ext, q.ptr_io,
                                         q.chan, q.dir, 1'b0};
            `HDG_R_COUNT:  d.sw_rdata = {16'h0, q.count};
            `HDG_R_PTR:    d.sw_rdata = {12'h0, q.ptr};
            `HDG_R_BASE:
            begin
               d.sw_rdata   = {16'h0, q.base};
               d.touched[0] = 1'b1;
            end
            `HDG_R_RANGE:
            begin
               d.sw_rdata   = {16'h0, q.rng};
               d.touched[1] = 1'b1;
            end
            `HDG_R_STAT:   d.sw_rdata = {30'h0, q.stat};
            `HDG_R_MASK:   d.sw_rdata = {30'h0, q.mask};
            `HDG_R_ACCESS: d.sw_rdata = {31'h0, q.man};
            `HDG_R_DATA:   d.sw_rdata = {16'h0, q.rdata};
            default:       d.sw_rdata = 32'h0000_0000;
         endcase
      end
      case (q.bus)
         HDG_IDLE:
         begin
            d.cur_dma = 1'b0;
            if (q.man)
            begin
               d.man      = 1'b0;
               d.cur_addr = q.man_acc[19:0];
               d.cur_io   = q.man_acc[`HDG_ACC_IO];
               d.cur_rd   = q.man_acc[`HDG_ACC_RD];
               d.wdata    = q.man_data;
               d.bus      = HDG_T1;
            end
            else if (q.busy && q.count == 16'h0000)
            begin
               d.busy    = 1'b0;
               d.stat[0] = 1'b1;
            end
            else if (q.busy && req && (q.dir || dl_valid))
            begin
               d.cur_dma  = 1'b1;
               d.cur_addr = q.ptr_io ? {`HDG_IO_TOP, q.ptr[15:0]} : q.ptr;
               d.cur_io   = q.ptr_io;
               d.cur_rd   = q.dir;
               d.wdata    = dl_data;
               d.bus      = HDG_T1;
            end
         end
         HDG_T1:
         begin
            d.lat_addr = q.cur_addr[15:0];
            d.bus      = HDG_T2;
         end
         HDG_T2:
         begin
            d.waits = rmode[1:0];
            d.bus   = HDG_T3;
         end
         HDG_T3, HDG_TW:
         begin
            if (q.waits != 2'h0)
            begin
               d.waits = q.waits - 2'h1;
               d.bus   = HDG_TW;
            end
            else if (rdy_ok)
            begin
               if (q.cur_rd)
                  d.rdata = lk.data;
               d.bus = HDG_T4;
            end
            else
               d.bus = HDG_TW;
         end
         HDG_T4:
         begin
            if (q.cur_dma)
            begin
               d.count = q.count - 16'h0001;
               if (q.cur_rd)
               begin
                  d.ul_data = q.rdata;
                  d.ul_pls  = 1'b1;
               end
            end
            d.bus = HDG_IDLE;
         end
         default: d.bus = HDG_IDLE;
      endcase
      // Events win over a clear in the same cycle, except a done event while the done flag is already set.
      d.stat[1] = (q.stat[1] & ~sclr[1]) | lk.dev_int;
      d.stat[0] = (q.stat[0] & ~sclr[0]) | d.stat[0] & ~q.stat[0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q         <= '0;
         q.bus     <= HDG_IDLE;
         q.ucs_ext <= `HDG_UCS_EXT;
         q.ucs_w   <= `HDG_UCS_WAITS;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign peripheral_select_line_n = ~(sel[6:0] & {7{bus_on}});
   assign upper_memory_select_n    = ~(sel[7] & bus_on);
   assign lk.sel_n   = peripheral_select_line_n[0];
   assign lk.reg_sel = q.lat_addr[2:1];
   assign lk.rd_n    = ~(stb & q.cur_rd);
   assign lk.wr_n    = ~(stb & ~q.cur_rd);
   assign lk.hd_out  = q.wdata;
   assign lk.hd_oe   = bus_on & ~q.cur_rd;
   assign lk.ack_n   = 1'b1;
   assign sw_rdata   = q.sw_rdata;
   assign irq        = |(q.stat & q.mask);
   assign ul_valid   = q.ul_pls;
   assign ul_data    = q.ul_data;
endmodule : hdg_host_end

// file: test/hdg_link_chk.sv
// Checker on the link pins between the host end and the device end.
// Assumes device accesses at select line 0 are set up for one wait state.
`timescale 1ns/1ps
`include "hdg_defs.svh"
module hdg_link_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Link pins
   input wire logic        sel_n,
   input wire logic [1:0]  reg_sel,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [15:0] data,
   input wire logic        hd_oe,
   input wire logic        dd_oe,
   input wire logic        data_queue_request,
   input wire logic        ireq,
   input wire logic        dev_int,
   input wire logic        ack_n
);
   logic [2:0] age_q;
   logic       strb;
   assign strb = !(rd_n && wr_n);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ------------------------------------------------------------
   // Cycles since the last enable or acknowledge write.
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         age_q <= 3'h7;
      else if (!sel_n && !wr_n && reg_sel[1])
         age_q <= 3'h0;
      else if (age_q != 3'h7)
         age_q <= age_q + 3'h1;
   end
   // ------------------------------------------------------------
   // Properties.
   // ------------------------------------------------------------
   property p_dl_drop;
      !sel_n && $fell(wr_n) && reg_sel == `HDG_D_DATA |=> !data_queue_request;
   endproperty
   a_dl_drop: assert property (p_dl_drop) else $error("data request kept after write");
   property p_in_drop;
      !sel_n && $fell(wr_n) && reg_sel == `HDG_D_INSTR |=> !ireq;
   endproperty
   a_in_drop: assert property (p_in_drop) else $error("instr request kept after write");
   property p_early;
      !sel_n && $rose(wr_n) && reg_sel == `HDG_D_DATA |-> !data_queue_request && !$past(data_queue_request);
   endproperty
   a_early: assert property (p_early) else $error("request late at cycle end");
   property p_ul_drop;
      !sel_n && $fell(rd_n) && reg_sel == `HDG_D_DATA |=> !data_queue_request [*2];
   endproperty
   a_ul_drop: assert property (p_ul_drop) else $error("request kept after read");
   property p_wait;
      !sel_n && $rose(strb) |-> strb [*3] ##1 !strb;
   endproperty
   a_wait: assert property (p_wait) else $error("strobe length wrong");
   property p_ack;
      ack_n;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge pin driven low");
   property p_int_hold;
      $fell(dev_int) |-> age_q < 3'h5;
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("interrupt dropped unacked");
   property p_oe;
      dd_oe |-> !sel_n && !hd_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("device drives bus unselected");
   property p_hold;
      !wr_n && $past(!wr_n) |-> $stable(data);
   endproperty
   a_hold: assert property (p_hold) else $error("write data moved in strobe");
   c_dl: cover property (!sel_n && $fell(wr_n) && reg_sel == `HDG_D_DATA);
   c_ul: cover property (!sel_n && $fell(rd_n) && reg_sel == `HDG_D_DATA);
   c_int: cover property ($fell(dev_int));
   c_in: cover property (!sel_n && $fell(wr_n) && reg_sel == `HDG_D_INSTR);
endmodule : hdg_link_chk

// file: test/host_dma_irq_select_glue_test.sv
// Self-checking bench: host end and device end joined by the link.
// Assumes the device sits at select line 0, base address zero.
`timescale 1ns/1ps
`include "hdg_defs.svh"
module host_dma_irq_select_glue_test;
   import hdg_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, mon_clr = 1'b0;
   logic        dl_valid = 1'b1, ext_ready = 1'b1, dl_ready, ul_valid, irq, umcs_n;
   logic        dl_space = 1'b0, in_space = 1'b0, ul_avail = 1'b0, dl_wr, in_wr, ul_taken;
   logic [3:0]  sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0, sw_rdata, rd_v;
   logic [6:0]  pcs_n, pcs_seen = 7'h00;
   logic        umcs_seen = 1'b0;
   hdg_word_t   dl_data = 16'hA500, du_data = 16'h5A00, ew = 16'hA500, eu = 16'h5A00;
   hdg_word_t   ul_data, dd_data;
   hdg_irq_t    irq_event = 4'h0;
   int          miscompares = 0, tests_run = 0, run = 0, slen = 0, nx = 0, n0;
   logic [7:0]  ctl [3] = '{8'h79, 8'h7D, 8'h7B};
   always #50 clk = ~clk;
   hdg_link_if lk ();
   hdg_host_end u_hdg_host_end (.clk(clk), .resetn(resetn), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
      .dl_valid(dl_valid), .dl_data(dl_data), .dl_ready(dl_ready), .ul_valid(ul_valid),
      .ul_data(ul_data), .ext_ready(ext_ready), .peripheral_select_line_n(pcs_n),
      .upper_memory_select_n(umcs_n), .lk(lk));
   hdg_dev_end u_hdg_dev_end (.clk(clk), .resetn(resetn), .lk(lk), .dl_space(dl_space),
      .dl_data(dd_data), .dl_wr(dl_wr), .in_wr(in_wr), .in_space(in_space),
      .ul_avail(ul_avail), .ul_data(du_data), .ul_taken(ul_taken), .irq_event(irq_event));
   hdg_link_chk u_hdg_link_chk (.clk(clk), .resetn(resetn), .sel_n(lk.sel_n),
      .reg_sel(lk.reg_sel), .rd_n(lk.rd_n), .wr_n(lk.wr_n), .data(lk.data), .hd_oe(lk.hd_oe),
      .dd_oe(lk.dd_oe), .data_queue_request(lk.data_queue_request), .ireq(lk.ireq), .dev_int(lk.dev_int), .ack_n(lk.ack_n));
   // ------------------------------------------------------------
   // Tasks.
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("compares=%0d mismatches=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // Every write also clears the select monitor for the next cycle.
   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      mon_clr  <= 1'b1;
      @(posedge clk);
      sw_wr    <= 1'b0;
      mon_clr  <= 1'b0;
   endtask : sw_write
   task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk);
      sw_rd   <= 1'b0;
      #1 d = sw_rdata;
   endtask : sw_read
   task automatic wait_val(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      for (int i = 0; i < 150; i++)
      begin
         sw_read(a, v);
         if ((v & m) === e)
            return;
      end
      chk(v & m, e);
      conclude();
   endtask : wait_val
   task automatic acc(input logic rd, input logic io, input logic [19:0] ad);
      sw_write(`HDG_R_ACCESS, {10'h000, rd, io, ad});
      wait_val(`HDG_R_ACCESS, 32'hFFFFFFFF, 32'h00000000);
      // The pending flag drops when the cycle starts, not when it ends.
      // The longest cycle used here has three waits, so ten clocks let
      // the selects, the strobe length and the read data settle.
      repeat (10) @(posedge clk);
   endtask : acc
   task automatic dev_wr(input logic [1:0] r, input logic [15:0] d);
      sw_write(`HDG_R_DATA, {16'h0000, d});
      acc(1'b0, 1'b1, {17'h00000, r, 1'b0});
   endtask : dev_wr
   // ------------------------------------------------------------
   // Monitor of strobes, selects and streamed words.
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!lk.rd_n || !lk.wr_n)
         run <= run + 1;
      else if (run != 0)
      begin
         slen <= run;
         run  <= 0;
      end
      pcs_seen  <= mon_clr ? 7'h00 : pcs_seen | ~pcs_n;
      umcs_seen <= mon_clr ? 1'b0 : umcs_seen | ~umcs_n;
      if (dl_wr)
      begin
         chk(32'(dd_data), 32'(ew));
         ew <= ew + 16'h0001;
      end
      if (ul_valid)
      begin
         chk(32'(ul_data), 32'(eu));
         eu <= eu + 16'h0001;
      end
      if (dl_wr || in_wr || ul_valid)
         nx <= nx + 1;
      if (dl_ready)
         dl_data <= dl_data + 16'h0001;
      if (ul_taken)
         du_data <= du_data + 16'h0001;
   end
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      sw_read(`HDG_R_CTRL, rd_v);
      chk(rd_v, 32'h00000070);
      sw_write(`HDG_R_BASE, 32'h00000005);
      acc(1'b1, 1'b0, 20'h00000);
      chk(32'(pcs_seen), 32'h0);
      acc(1'b1, 1'b0, 20'hFFC00);
      chk({24'h0, pcs_seen, umcs_seen}, 32'h00000001);
      chk(32'(slen), 32'h5);
      @(posedge clk);
      ext_ready <= 1'b0;
      sw_write(`HDG_R_ACCESS, 32'h002FFC00);
      repeat (12) @(posedge clk);
      chk(32'(lk.rd_n), 32'h0);
      ext_ready <= 1'b1;
      wait_val(`HDG_R_ACCESS, 32'hFFFFFFFF, 32'h00000000);
      // Memory space first, so the device ends up in I/O space.
      for (int m = 1; m >= 0; m--)
      begin
         sw_write(`HDG_R_RANGE, {24'h0, m[0], 7'h05});
         @(posedge clk);
         ext_ready <= 1'b0;
         for (int k = 0; k < 7; k++)
         begin
            acc(1'b1, ~m[0], 20'(k * 128 + 4));
            chk(32'(pcs_seen), 32'(7'h01 << k));
            chk(32'(slen), 32'h3);
         end
         @(posedge clk);
         ext_ready <= 1'b1;
         acc(1'b1, m[0], 20'h00004);
         chk(32'(pcs_seen), 32'h0);
      end
      dev_wr(`HDG_D_ENABLE, 16'h0003);
      sw_write(`HDG_R_MASK, 32'h00000002);
      @(posedge clk);
      irq_event <= 4'h7;
      @(posedge clk);
      irq_event <= 4'h0;
      repeat (4) @(posedge clk);
      #1 chk({30'h0, lk.dev_int, irq}, 32'h3);
      sw_write(`HDG_R_MASK, 32'h00000000);
      @(posedge clk);
      #1 chk(32'(irq), 32'h0);
      sw_write(`HDG_R_MASK, 32'h00000002);
      dev_wr(`HDG_D_ACK, 16'h0001);
      acc(1'b1, 1'b1, 20'h00006);
      sw_read(`HDG_R_DATA, rd_v);
      chk(rd_v, 32'h00000006);
      chk(32'(lk.dev_int), 32'h1);
      dev_wr(`HDG_D_ACK, 16'h0006);
      repeat (2) @(posedge clk);
      sw_write(`HDG_R_STAT, 32'h00000002);
      @(posedge clk);
      #1 chk({30'h0, lk.dev_int, irq}, 32'h0);
      // Data download, instruction download, then upload, all in I/O space.
      for (int c = 0; c < 3; c++)
      begin
         @(posedge clk);
         dl_space <= (c == 0);
         in_space <= (c == 1);
         ul_avail <= (c == 2);
         n0 = nx;
         sw_write(`HDG_R_COUNT, 32'h00000003);
         sw_write(`HDG_R_PTR, (c == 1) ? 32'h000F0002 : 32'h000F0000);
         sw_write(`HDG_R_CTRL, {24'h0, ctl[c]});
         wait_val(`HDG_R_STAT, 32'h00000001, 32'h00000001);
         repeat (4) @(posedge clk);
         chk(32'(nx - n0), 32'h3);
         sw_write(`HDG_R_STAT, 32'h00000001);
      end
      conclude();
   end
endmodule : host_dma_irq_select_glue_test
